//--- design/fetch_if.sv
// carrier between register front end and line address generator
`timescale 1ns/1ps
interface fetch_if;
  overlay_window_pkg::dword_addr_type start;
  overlay_window_pkg::stride_type     stride;
  logic                               enable;
  logic                               frame_start;
  logic                               line_start;
  logic                               issue;
  overlay_window_pkg::dword_addr_type issue_addr;
  overlay_window_pkg::line_cnt_type   line_cnt;
  logic                               active;

  modport front (output start, output stride, output enable,
                 output frame_start, output line_start,
                 input issue, input issue_addr, input line_cnt,
                 input active);
  modport gen (input start, input stride, input enable,
               input frame_start, input line_start,
               output issue, output issue_addr, output line_cnt,
               output active);
endinterface

//--- design/line_address_gen.sv
// per-line overlay fetch address accumulator
`timescale 1ns/1ps
`include "overlay_window_consts.svh"
module line_address_gen (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  fetch_if.gen      fif
);
  overlay_window_pkg::dword_addr_type next_addr_reg, next_addr_next;
  overlay_window_pkg::stride_type     stride_reg, stride_next;
  overlay_window_pkg::dword_addr_type issue_addr_reg, issue_addr_next;
  overlay_window_pkg::line_cnt_type   line_cnt_reg, line_cnt_next;
  logic                               active_reg, active_next;
  logic                               issue_reg, issue_next;
  overlay_window_pkg::dword_addr_type base;

  // ----------------------------------------------------------------------
  // next-state: start and stride are sampled once per frame so that a
  // mid-frame register write cannot tear the window
  // ----------------------------------------------------------------------
  always_comb begin
    next_addr_next  = next_addr_reg;
    stride_next     = stride_reg;
    issue_addr_next = issue_addr_reg;
    line_cnt_next   = line_cnt_reg;
    active_next     = active_reg;
    issue_next      = 1'b0;
    base            = next_addr_reg;
    if (fif.frame_start) begin
      base          = fif.start;                    // [R01] [R06]
      next_addr_next = fif.start;
      stride_next   = fif.stride;                   // [R05]
      active_next   = fif.enable;                   // [R04]
      line_cnt_next = `LINE_CNT_RESET;
    end
    if (fif.line_start && (fif.frame_start ? fif.enable : active_reg)) begin
      issue_next      = 1'b1;                       // [R04]
      issue_addr_next = base;                       // [R02] [R03]
      // wraps in 17 bits: the window may straddle the end of memory
      next_addr_next  = dword_addr_type_add(base,
                          fif.frame_start ? fif.stride : stride_reg);
      line_cnt_next   = fif.frame_start ? 11'h001
                                        : line_cnt_reg + 11'h001;
    end
  end

  // double-word addition, result cut back to 17 bits [R06]
  function automatic overlay_window_pkg::dword_addr_type dword_addr_type_add(
      input overlay_window_pkg::dword_addr_type a,
      input overlay_window_pkg::stride_type     s);
    logic [17:0] sum;
    sum = {1'b0, a} + {8'h00, s};
    return sum[16:0];
  endfunction

  // registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      next_addr_reg  <= `START_RESET;
      stride_reg     <= `STRIDE_RESET;
      issue_addr_reg <= `START_RESET;
      line_cnt_reg   <= `LINE_CNT_RESET;
      active_reg     <= `WIN_ENABLE_RESET;
      issue_reg      <= 1'b0;
    end else if (ce) begin
      next_addr_reg  <= next_addr_next;
      stride_reg     <= stride_next;
      issue_addr_reg <= issue_addr_next;
      line_cnt_reg   <= line_cnt_next;
      active_reg     <= active_next;
      issue_reg      <= issue_next;
    end
  end

  assign fif.issue      = issue_reg;
  assign fif.issue_addr = issue_addr_reg;
  assign fif.line_cnt   = line_cnt_reg;
  assign fif.active     = active_reg;
endmodule // line_address_gen

//--- design/overlay_window_consts.svh
// register offsets, field positions, reset values for the overlay fetch
`ifndef OVERLAY_WINDOW_CONSTS_SVH
`define OVERLAY_WINDOW_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ----------------------------------------------------------------------
`define DISPLAY_CTRL_OFS    8'h10
`define OVL_START_OFS       8'h50
`define OVL_STRIDE_OFS      8'h54
`define OVL_FETCH_STAT_OFS  8'h70
`define OVL_LINE_STAT_OFS   8'h74

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define WIN_ENABLE_BIT      19
`define START_MSB           16
`define STRIDE_MSB          9
`define LINE_CNT_MSB        10
`define ACTIVE_BIT          31

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define START_RESET         17'h0_0000
`define STRIDE_RESET        10'h000
`define LINE_CNT_RESET      11'h000
`define WIN_ENABLE_RESET    1'h0
`define RDATA_RESET         32'h0000_0000

`endif

//--- design/overlay_window_fetch_address.sv
// overlay window fetch address generator with register front end
//
// Functional notes
// R01 - 17-bit start address is first fetched word
// R02 - start address counts 32-bit words, not bytes
// R03 - zero is first word, one the second
// R04 - start ignored unless window enable bit set
// R05 - 10-bit stride between consecutive window line starts
// R06 - line n address is start plus n strides
`timescale 1ns/1ps
`include "overlay_window_consts.svh"
module overlay_window_fetch_address (
  input  wire  logic        clk,
  input  wire  logic        reset,
  input  wire  logic        ce,
  input  wire  logic [7:0]  reg_addr,
  input  wire  logic [31:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic       [31:0] reg_rdata,
  input  wire  logic        frame_start,
  input  wire  logic        line_start,
  output logic       [16:0] fetch_addr,
  output logic              fetch_valid,
  output logic              window_enable
);
  // ----------------------------------------------------------------------
  // software visible state
  // ----------------------------------------------------------------------
  overlay_window_pkg::dword_addr_type start_reg, start_next;
  overlay_window_pkg::stride_type     stride_reg, stride_next;
  logic                               enable_reg, enable_next;
  logic [31:0]                        rdata_reg, rdata_next;

  // ----------------------------------------------------------------------
  // fetch outputs
  // ----------------------------------------------------------------------
  overlay_window_pkg::dword_addr_type fetch_addr_reg, fetch_addr_next;
  logic                               fetch_valid_reg, fetch_valid_next;

  fetch_if fif ();

  // ----------------------------------------------------------------------
  // carrier to the line address generator
  // ----------------------------------------------------------------------
  assign fif.start       = start_reg;
  assign fif.stride      = stride_reg;
  assign fif.enable      = enable_reg;
  assign fif.frame_start = frame_start;
  assign fif.line_start  = line_start;

  line_address_gen gen_inst (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .fif   (fif.gen)
  );

  // ----------------------------------------------------------------------
  // register writes: only the documented field widths are kept
  // ----------------------------------------------------------------------
  always_comb begin
    start_next  = start_reg;
    stride_next = stride_reg;
    enable_next = enable_reg;
    if (reg_wr) begin
      if (reg_addr == `OVL_START_OFS) begin
        start_next = reg_wdata[`START_MSB:0];              // [R01]
      end else if (reg_addr == `OVL_STRIDE_OFS) begin
        stride_next = reg_wdata[`STRIDE_MSB:0];            // [R05]
      end else if (reg_addr == `DISPLAY_CTRL_OFS) begin
        enable_next = reg_wdata[`WIN_ENABLE_BIT];          // [R04]
      end
    end
  end

  // ----------------------------------------------------------------------
  // register reads: answer one cycle after the strobe, zero otherwise;
  // unmapped offsets and reserved bits read as zero
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = `RDATA_RESET;
    if (reg_rd) begin
      if (reg_addr == `OVL_START_OFS) begin
        rdata_next[`START_MSB:0] = start_reg;
      end else if (reg_addr == `OVL_STRIDE_OFS) begin
        rdata_next[`STRIDE_MSB:0] = stride_reg;
      end else if (reg_addr == `DISPLAY_CTRL_OFS) begin
        rdata_next[`WIN_ENABLE_BIT] = enable_reg;
      end else if (reg_addr == `OVL_FETCH_STAT_OFS) begin
        rdata_next[`START_MSB:0] = fif.issue_addr;          // last line
      end else if (reg_addr == `OVL_LINE_STAT_OFS) begin
        rdata_next[`LINE_CNT_MSB:0] = fif.line_cnt;
        rdata_next[`ACTIVE_BIT]     = fif.active;
      end
    end
  end

  // ----------------------------------------------------------------------
  // fetch output staging: the generator already applies the enable, so
  // only its qualified issue pulse reaches the memory side
  // ----------------------------------------------------------------------
  always_comb begin
    fetch_addr_next  = fetch_addr_reg;
    fetch_valid_next = fif.issue;                          // [R04]
    if (fif.issue) begin
      fetch_addr_next = fif.issue_addr;                    // [R02] [R06]
    end
  end

  // registers only; ce low freezes everything including read data
  always_ff @(posedge clk) begin
    if (reset) begin
      start_reg       <= `START_RESET;
      stride_reg      <= `STRIDE_RESET;
      enable_reg      <= `WIN_ENABLE_RESET;
      rdata_reg       <= `RDATA_RESET;
      fetch_addr_reg  <= `START_RESET;
      fetch_valid_reg <= 1'b0;
    end else if (ce) begin
      start_reg       <= start_next;
      stride_reg      <= stride_next;
      enable_reg      <= enable_next;
      rdata_reg       <= rdata_next;
      fetch_addr_reg  <= fetch_addr_next;
      fetch_valid_reg <= fetch_valid_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------------
  assign reg_rdata     = rdata_reg;
  assign fetch_addr    = fetch_addr_reg;
  assign fetch_valid   = fetch_valid_reg;
  assign window_enable = enable_reg;
endmodule // overlay_window_fetch_address

//--- design/overlay_window_pkg.sv
// shared types of the overlay window fetch address block
package overlay_window_pkg;
  typedef logic [16:0] dword_addr_type;  // double-word display address
  typedef logic [9:0]  stride_type;      // double-word line stride
  typedef logic [10:0] line_cnt_type;    // lines issued this frame
endpackage

//--- verif/overlay_window_fetch_address_sva.sv
// concurrent checks on the ports of the overlay fetch address block
`timescale 1ns/1ps
module overlay_window_fetch_address_sva (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        frame_start,
  input wire logic        line_start,
  input wire logic [16:0] fetch_addr,
  input wire logic        fetch_valid,
  input wire logic        window_enable
);
  logic [16:0] sh_st;
  logic [16:0] acc;
  logic [16:0] ea;
  logic [9:0]  sh_sd;
  logic [9:0]  fr_sd;
  logic        sh_en;
  logic        fr_en;
  logic        iss;
  // ----------------------------------------------------------------------
  // register shadow and per-frame snapshot
  // ----------------------------------------------------------------------
  assign iss = ce && line_start && (frame_start ? sh_en : fr_en);
  assign ea  = frame_start ? sh_st : acc;
  // acc holds the address that the next line of this frame will use
  always_ff @(posedge clk) begin
    if (reset) begin
      {sh_st, acc, sh_sd, fr_sd, sh_en, fr_en} <= '0;
    end else if (ce) begin
      if (reg_wr && reg_addr == 8'h50) sh_st <= reg_wdata[16:0];
      if (reg_wr && reg_addr == 8'h54) sh_sd <= reg_wdata[9:0];
      if (reg_wr && reg_addr == 8'h10) sh_en <= reg_wdata[19];
      if (frame_start) begin
        fr_en <= sh_en;
        fr_sd <= sh_sd;
        acc   <= sh_st + (line_start ? {7'h00, sh_sd} : 17'h0_0000);
      end else if (line_start) begin
        acc <= acc + {7'h00, fr_sd};
      end
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_issued;
    ##2 fetch_valid;
  endsequence
  sequence s_quiet;
    ##2 !fetch_valid;
  endsequence
  a_line_addr: assert property (
    iss |-> s_issued ##0 fetch_addr == $past(ea, 2))
    else $error("line fetch address wrong or missing");
  a_no_issue: assert property (!iss |-> s_quiet)
    else $error("fetch issued without enabled line start");
  a_addr_hold: assert property (!fetch_valid |-> $stable(fetch_addr))
    else $error("fetch address moved without valid");
  // a strobe seen while ce is low is not taken, so each check needs ce
  a_en_copy: assert property (
    ce && reg_wr && reg_addr == 8'h10
    |=> window_enable == $past(reg_wdata[19]))
    else $error("window enable copy wrong");
  a_start_read: assert property (
    ce && reg_rd && reg_addr == 8'h50
    |=> reg_rdata == {15'h0000, sh_st})
    else $error("start address read back wrong");
  a_stride_read: assert property (
    ce && reg_rd && reg_addr == 8'h54
    |=> reg_rdata == {22'h00_0000, sh_sd})
    else $error("stride read back wrong");
  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not idle");
endmodule // overlay_window_fetch_address_sva

//--- verif/tb.sv
// self-checking testbench of the overlay fetch address block
`timescale 1ns/1ps
module tb;
  logic        clk, reset, ce, reg_wr, reg_rd, frame_start, line_start;
  logic        fetch_valid, window_enable;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [16:0] fetch_addr;
  integer      seed = 36573;
  int          error_cnt = 0;
  int          tests_run = 0;
  overlay_window_fetch_address i_dut (.clk(clk), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start),
    .line_start(line_start), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .window_enable(window_enable));
  // line n address wraps at 17 bits
  function automatic logic [16:0] exp_addr(logic [16:0] s, logic [9:0] d,
                                           int n);
    return s + 17'(n) * {7'h00, d};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // answer comes two cycles after the line start is taken
  task automatic line(input logic v, input logic [16:0] ea);
    @(posedge clk); line_start <= 1'b1;
    @(posedge clk); line_start <= 1'b0;
    @(posedge clk);
    #1 chk(fetch_valid, v);
    if (v) chk(fetch_addr, ea);
  endtask
  // ce low freezes all state: a write and a line start are both lost
  task automatic freeze;
    @(posedge clk);
    ce         <= 1'b0;
    reg_addr   <= 8'h10;
    reg_wdata  <= 32'h0000_0000;
    reg_wr     <= 1'b1;
    line_start <= 1'b1;
    @(posedge clk);
    reg_wr     <= 1'b0;
    line_start <= 1'b0;
    @(posedge clk);
    ce         <= 1'b1;
    @(posedge clk);
    #1 chk(window_enable, 1'b1);
    chk(fetch_valid, 1'b0);
    rd(8'h10, 32'h0008_0000);
    $display("clock enable test done");
  endtask
  // reserved bits of start and stride are written high; a mid-frame write must not apply yet
  task automatic frame(input logic [16:0] st, input logic [9:0] sd,
                       input logic en, input logic same);
    logic [31:0] r;
    int          n;
    r = $random(seed);
    wr(8'h50, {15'h7fff, st});
    wr(8'h54, {22'h3f_ffff, sd});
    wr(8'h10, {12'h000, en, 19'h0_0000});
    rd(8'h50, {15'h0000, st});
    rd(8'h54, {22'h00_0000, sd});
    chk(window_enable, en);
    @(posedge clk); frame_start <= 1'b1; line_start <= same;
    @(posedge clk); frame_start <= 1'b0; line_start <= 1'b0;
    @(posedge clk);
    #1 chk(fetch_valid, same & en);
    if (same & en) chk(fetch_addr, st);
    n = same;
    for (int k = 0; k < 3; k++) begin
      if (k == 1) wr(8'h50, r);
      line(en, exp_addr(st, sd, n));
      n++;
    end
    // status: last issued line and lines issued in this frame
    if (en) rd(8'h70, {15'h0000, exp_addr(st, sd, n - 1)});
    rd(8'h74, {en, 20'h0_0000, en ? 11'(n) : 11'h000});
    $display("frame test done start=%h stride=%h en=%b", st, sd, en);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    reset = 1'b1; ce = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0; reg_rd = 1'b0; frame_start = 1'b0; line_start = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(8'h50, 32'h0000_0000);
    rd(8'h54, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wr(8'h5c, 32'hffff_ffff);
    rd(8'h5c, 32'h0000_0000);
    $display("register test done");
    frame(17'h0_0000, 10'h001, 1'b1, 1'b0);
    freeze;
    frame(17'h1_ffff, 10'h3ff, 1'b1, 1'b1);
    frame(17'h0_1234, 10'h010, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      frame(r[16:0], r[26:17], r[27], r[28]);
    end
    report_and_stop;
  end
endmodule // tb
bind overlay_window_fetch_address overlay_window_fetch_address_sva i_sva (
  .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .frame_start(frame_start),
  .line_start(line_start), .fetch_addr(fetch_addr),
  .fetch_valid(fetch_valid), .window_enable(window_enable));
